// [core/power_mgmt_status_ctrl.v]
// Purpose: Power management status/control registers on AHB-Lite
// Assumes: Comparator and stop inputs asynchronous; one bus clock
// Notes: Zero wait-state slave, always OKAY
// Operation
// - Detect flag sets on detect event only when detection enabled; bit 7 read-only
// - Writing 1 to detect ack clears detect flag; ack reads 0
// - Detect interrupt requested while flag set and interrupt enable is 1
// - Reset forced when flag sets, reset enable and detect enable both 1
// - Stop enable keeps detection alive in stop when 1
// - Detect enable gates the flag, reset and stop controls
// - Bit 0 enables the bandgap reference buffer
// - Warning flag is sticky while or since warning present
// - Warning ack clears flag only when no warning now present
// - Warning flag sets on trip crossing or after reset when already low
// - Detect trip select takes only first write after power-on reset
// - Warning trip select cleared by power-on reset only
// - Partial power down flag shows recovery from deep stop
// - Writing 1 to partial power down ack clears its flag
// - Stop depth control takes only first write after any reset
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`include "pwr_mgmt_consts.vh"
`default_nettype none

module power_mgmt_status_ctrl (
    // Bus clock and reset
    input wire hclk,
    input wire hresetn,
    // Power-on reset indication, high for a power-on reset
    input wire por_event,
    // AHB-Lite slave
    input wire hsel,
    input wire [3:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // Analog comparator and power state inputs
    input wire lv_detect_cmp,
    input wire lv_warn_cmp,
    input wire in_stop,
    input wire ppd_recovered,
    // Controls to analog and system
    output reg detect_trip_select,
    output reg warn_trip_select,
    output reg stop_depth_ctrl,
    output reg bandgap_buffer_en,
    output reg lv_detect_active,
    output reg lv_reset_req,
    output reg irq
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg lv_detect_flag;
    reg lv_detect_irq_en;
    reg lv_detect_reset_en;
    reg lv_detect_stop_en;
    reg lv_detect_en;
    reg lv_warn_flag;
    reg partial_pd_flag;
    reg trip_written;
    reg depth_written;
    reg [`IRQ_WIDTH-1:0] irq_status;
    reg [`IRQ_WIDTH-1:0] irq_enable;
    reg [1:0] det_sync;
    reg [1:0] warn_sync;
    reg [1:0] stop_sync;
    reg [1:0] ppd_sync;
    reg det_prev;
    reg ppd_prev;
    reg wr_pend;
    reg [3:0] wr_addr;
    reg rst_seen;

    // Next values of the stored fields
    reg next_irq_en;
    reg next_reset_en;
    reg next_stop_en;
    reg next_det_en;
    reg next_bandgap;
    reg next_det_flag;
    reg next_warn_flag;
    reg next_ppd_flag;
    reg next_det_trip;
    reg next_warn_trip;
    reg next_trip_written;
    reg next_stop_depth;
    reg next_depth_written;
    reg [`IRQ_WIDTH-1:0] next_irq_enable;
    // Reset images of the two byte registers
    localparam [7:0] CTRL_ONE_INIT = `CTRL_ONE_RESET;
    localparam [7:0] CTRL_TWO_INIT = `CTRL_TWO_RESET;

    // Stable synchronised values
    wire det_now = det_sync[1];
    wire warn_now = warn_sync[1];
    wire stop_now = stop_sync[1];
    wire ppd_now = ppd_sync[1];

    // Bus decode
    wire addr_phase = hsel & hready & htrans[1];
    wire wr_one = wr_pend & (wr_addr == `OFS_CTRL_ONE);
    wire wr_two = wr_pend & (wr_addr == `OFS_CTRL_TWO);
    wire wr_ien = wr_pend & (wr_addr == `OFS_IRQ_ENABLE);
    wire wr_clr = wr_pend & (wr_addr == `OFS_IRQ_STATUS);

    wire detect_live = lv_detect_en & (~stop_now | lv_detect_stop_en);
    wire det_event = detect_live & det_now & ~det_prev;
    wire ppd_event = ppd_now & ~ppd_prev;
    wire det_clear = wr_one & hwdata[`BIT_DET_ACK];
    wire warn_clear = wr_two & hwdata[`BIT_WARN_ACK] & ~warn_now;
    wire ppd_clear = wr_two & hwdata[`BIT_PPD_ACK];
    wire [`IRQ_WIDTH-1:0] irq_events = {ppd_event, warn_now & ~lv_warn_flag, det_event};
    wire [`IRQ_WIDTH-1:0] irq_clr_mask = wr_clr ? hwdata[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};
    // Set wins over clear on the same cycle
    wire [`IRQ_WIDTH-1:0] next_irq_status = irq_events | (irq_status & ~irq_clr_mask);

    // ----------------------------------------
    // Next register values
    // ----------------------------------------
    // Shared by the registers and the read path, so a read issued in the
    // data phase of a write already returns the written value
    always @* begin
        next_irq_en = lv_detect_irq_en;
        next_reset_en = lv_detect_reset_en;
        next_stop_en = lv_detect_stop_en;
        next_det_en = lv_detect_en;
        next_bandgap = bandgap_buffer_en;
        next_det_flag = lv_detect_flag;
        next_warn_flag = lv_warn_flag;
        next_ppd_flag = partial_pd_flag;
        next_det_trip = detect_trip_select;
        next_warn_trip = warn_trip_select;
        next_trip_written = trip_written;
        next_stop_depth = stop_depth_ctrl;
        next_depth_written = depth_written;
        next_irq_enable = irq_enable;
        // Control one fields, reserved bit 1 not stored
        if (wr_one) begin
            next_irq_en = hwdata[`BIT_DET_IRQ_EN];
            next_reset_en = hwdata[`BIT_DET_RST_EN];
            next_stop_en = hwdata[`BIT_DET_STOP_EN];
            next_det_en = hwdata[`BIT_DET_EN];
            next_bandgap = hwdata[`BIT_BANDGAP_EN];
        end
        if (det_event) begin
            next_det_flag = 1'b1;
        end else if (det_clear) begin
            next_det_flag = 1'b0;
        end
        if (warn_now) begin
            next_warn_flag = 1'b1;
        end else if (warn_clear) begin
            next_warn_flag = 1'b0;
        end
        if (ppd_event) begin
            next_ppd_flag = 1'b1;
        end else if (ppd_clear) begin
            next_ppd_flag = 1'b0;
        end
        if (!rst_seen & por_event) begin
            next_det_trip = 1'b0;
            next_warn_trip = 1'b0;
            next_trip_written = 1'b0;
        end else if (wr_two) begin
            next_warn_trip = hwdata[`BIT_WARN_TRIP];
            if (!trip_written) begin
                next_det_trip = hwdata[`BIT_DET_TRIP];
                next_trip_written = 1'b1;
            end
        end
        if (wr_two & ~depth_written) begin
            next_stop_depth = hwdata[`BIT_STOP_DEPTH];
            next_depth_written = 1'b1;
        end
        // Interrupt enable register
        if (wr_ien) begin
            next_irq_enable = hwdata[`IRQ_WIDTH-1:0];
        end
    end

    // ----------------------------------------
    // Comparator and power state synchronisers
    // ----------------------------------------
    // two-stage synchronisers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            det_sync <= 2'h0;
            warn_sync <= 2'h0;
            stop_sync <= 2'h0;
            ppd_sync <= 2'h0;
            det_prev <= 1'b0;
            ppd_prev <= 1'b0;
        end else begin
            det_sync <= {det_sync[0], lv_detect_cmp};
            warn_sync <= {warn_sync[0], lv_warn_cmp};
            stop_sync <= {stop_sync[0], in_stop};
            ppd_sync <= {ppd_sync[0], ppd_recovered};
            det_prev <= det_now;
            ppd_prev <= ppd_now;
        end
    end

    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    // Write address held for the data phase; reads answered next cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 4'h0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= addr_phase & hwrite;
            wr_addr <= haddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_phase & ~hwrite) begin
                case (haddr)
                    `OFS_CTRL_ONE: hrdata <= {24'h000000, next_det_flag, 1'b0,
                        next_irq_en, next_reset_en, next_stop_en,
                        next_det_en, 1'b0, next_bandgap};
                    `OFS_CTRL_TWO: hrdata <= {24'h000000, next_warn_flag, 1'b0,
                        next_det_trip, next_warn_trip, next_ppd_flag,
                        2'h0, next_stop_depth};
                    `OFS_IRQ_STATUS: hrdata <= {29'h0, next_irq_status};
                    `OFS_IRQ_ENABLE: hrdata <= {29'h0, next_irq_enable};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Control one register
    // ----------------------------------------
    // Control one storage
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lv_detect_irq_en <= CTRL_ONE_INIT[`BIT_DET_IRQ_EN];
            lv_detect_reset_en <= CTRL_ONE_INIT[`BIT_DET_RST_EN];
            lv_detect_stop_en <= CTRL_ONE_INIT[`BIT_DET_STOP_EN];
            lv_detect_en <= CTRL_ONE_INIT[`BIT_DET_EN];
            bandgap_buffer_en <= CTRL_ONE_INIT[`BIT_BANDGAP_EN];
        end else begin
            lv_detect_irq_en <= next_irq_en;
            lv_detect_reset_en <= next_reset_en;
            lv_detect_stop_en <= next_stop_en;
            lv_detect_en <= next_det_en;
            bandgap_buffer_en <= next_bandgap;
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lv_detect_flag <= CTRL_ONE_INIT[`BIT_DET_FLAG];
            lv_warn_flag <= CTRL_TWO_INIT[`BIT_WARN_FLAG];
            partial_pd_flag <= CTRL_TWO_INIT[`BIT_PPD_FLAG];
        end else begin
            lv_detect_flag <= next_det_flag;
            lv_warn_flag <= next_warn_flag;
            partial_pd_flag <= next_ppd_flag;
        end
    end

    // ----------------------------------------
    // Trip selects, power-on domain
    // ----------------------------------------
    // Caught while reset is held and on the first edge after release: power-on clears, other resets keep
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_seen <= 1'b0;
        end else begin
            rst_seen <= 1'b1;
        end
    end

    // Trip selects hold through every reset but power-on
    always @(posedge hclk) begin
        detect_trip_select <= next_det_trip;
        warn_trip_select <= next_warn_trip;
        trip_written <= next_trip_written;
    end

    // Stop depth cleared by every reset
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_depth_ctrl <= CTRL_TWO_INIT[`BIT_STOP_DEPTH];
            depth_written <= 1'b0;
        end else begin
            stop_depth_ctrl <= next_stop_depth;
            depth_written <= next_depth_written;
        end
    end

    // ----------------------------------------
    // Interrupt status, enable and outputs
    // ----------------------------------------
    // Set wins over clear on the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 3'h0;
            irq_enable <= 3'h0;
            irq <= 1'b0;
            lv_reset_req <= 1'b0;
            lv_detect_active <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq <= (lv_detect_irq_en & lv_detect_flag) | |(irq_status & irq_enable);
            lv_reset_req <= lv_detect_reset_en & lv_detect_en & lv_detect_flag;
            lv_detect_active <= detect_live;
        end
    end

endmodule

`default_nettype wire

// [include/pwr_mgmt_consts.vh]
// Purpose: Constants for the power management status and control block
// Assumes: AHB-Lite slave, 32-bit words, byte registers in the low bits
// Notes: Offsets are byte addresses within the block
`ifndef PWR_MGMT_CONSTS_VH
`define PWR_MGMT_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL_ONE 4'h0
`define OFS_CTRL_TWO 4'h4
`define OFS_IRQ_STATUS 4'h8
`define OFS_IRQ_ENABLE 4'hC

// ----------------------------------------
// Control one fields
// ----------------------------------------
`define BIT_DET_FLAG 7
`define BIT_DET_ACK 6
`define BIT_DET_IRQ_EN 5
`define BIT_DET_RST_EN 4
`define BIT_DET_STOP_EN 3
`define BIT_DET_EN 2
`define BIT_RESERVED_ONE 1
`define BIT_BANDGAP_EN 0
`define CTRL_ONE_RESET 8'h1C

// ----------------------------------------
// Control two fields
// ----------------------------------------
`define BIT_WARN_FLAG 7
`define BIT_WARN_ACK 6
`define BIT_DET_TRIP 5
`define BIT_WARN_TRIP 4
`define BIT_PPD_FLAG 3
`define BIT_PPD_ACK 2
`define BIT_STOP_DEPTH 0
`define CTRL_TWO_RESET 8'h00

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_DETECT 0
`define IRQ_WARN 1
`define IRQ_PPD 2
`define IRQ_WIDTH 3

`endif

// [tb/power_mgmt_status_ctrl_chk.sv]
// Purpose: Port checker for the power management block
// Assumes: A write lands two edges after its address phase
// Notes: Bound to the block at the foot of this file
`default_nettype none
module power_mgmt_status_ctrl_chk (
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_event,
    input wire logic [3:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    // Comparator and controls
    input wire logic lv_detect_cmp,
    input wire logic detect_trip_select,
    input wire logic warn_trip_select,
    input wire logic stop_depth_ctrl,
    input wire logic bandgap_buffer_en,
    input wire logic lv_reset_req,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wa;
    // Write taken in an address phase
    assign wa = hreadyout && htrans[1] && hwrite;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    bus_ready_a: assert property (hreadyout)
        else $error("slave stalled");
    okay_resp_a: assert property (!hresp)
        else $error("error response");
    det_trip_a: assert property ($changed(detect_trip_select) && !$past(por_event, 2)
        |-> $past(wa && haddr == 4'h4, 2)) else $error("detect trip moved");
    warn_trip_a: assert property ($changed(warn_trip_select) && !$past(por_event, 2)
        |-> $past(wa && haddr == 4'h4, 2)) else $error("warn trip moved");
    stop_depth_a: assert property ($changed(stop_depth_ctrl)
        |-> $past(wa && haddr == 4'h4, 2)) else $error("stop depth moved");
    bandgap_set_a: assert property ($changed(bandgap_buffer_en)
        |-> $past(wa && haddr == 4'h0, 2)) else $error("bandgap moved");
    reset_sync_a: assert property ($rose(lv_reset_req)
        |-> $past(lv_detect_cmp, 4) || $past(wa, 3)) else $error("reset request early");
    reset_drop_a: assert property ($fell(lv_reset_req)
        |-> $past(wa, 2) || $past(wa, 3)) else $error("reset request dropped");
    irq_drop_a: assert property ($fell(irq)
        |-> $past(wa, 2) || $past(wa, 3)) else $error("interrupt dropped");
endmodule
bind power_mgmt_status_ctrl power_mgmt_status_ctrl_chk power_mgmt_status_ctrl_chk_i (.hclk,
    .hresetn, .por_event, .haddr, .htrans, .hwrite, .hreadyout, .hresp, .lv_detect_cmp, .irq,
    .detect_trip_select, .warn_trip_select, .stop_depth_ctrl, .bandgap_buffer_en, .lv_reset_req);
`default_nettype wire

// [tb/power_mgmt_status_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the power management block
// Assumes: Zero wait-state bus, comparators seen 3 cycles late
// Notes: Write-once selects are written before anything else
`default_nettype none
module power_mgmt_status_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, por_event, hwrite, hreadyout, irq, lv_reset_req, lv_detect_active;
    logic lv_detect_cmp, lv_warn_cmp, in_stop, ppd_recovered, bandgap_buffer_en;
    logic detect_trip_select, warn_trip_select, stop_depth_ctrl;
    logic [1:0] htrans;
    logic [3:0] haddr;
    logic [31:0] hwdata, hrdata;
    logic [7:0] rdat;
    int failures, n_compared;
    // Block under test, always selected
    power_mgmt_status_ctrl power_mgmt_status_ctrl_i (.hclk, .hresetn, .por_event, .hsel(1'h1),
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
        .hresp(), .hrdata, .lv_detect_cmp, .lv_warn_cmp, .in_stop, .ppd_recovered, .irq,
        .detect_trip_select, .warn_trip_select, .stop_depth_ctrl, .bandgap_buffer_en,
        .lv_detect_active, .lv_reset_req);
    // Bus clock
    initial begin
        hclk = 1'h0;
        forever #2 hclk = ~hclk;
    end
    task automatic summarize;
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // One bus phase, bounded wait for ready
    task automatic hop;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 16);
        if (hreadyout !== 1'h1) begin
            failures++;
            $display("wrong value at %0t: no ready", $time);
            summarize;
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hop;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        hop;
        rdat = hrdata[7:0];
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(a, 1'h0, 8'h00);
        cmp(rdat, e);
    endtask
    task automatic rst(input logic p);
        hresetn <= 1'h0;
        por_event <= p;
        tick(2);
        hresetn <= 1'h1;
        tick(1);
        por_event <= 1'h0;
    endtask
    // Write-once selects across a later reset
    task automatic t_once;
        bus(4'h4, 1'h1, 8'h31);
        bus(4'h4, 1'h1, 8'h00);
        rd(4'h4, 8'h21);
        cmp({5'h0, detect_trip_select, warn_trip_select, stop_depth_ctrl}, 8'h05);
        bus(4'h4, 1'h1, 8'h10);
        rst(1'h0);
        rd(4'h4, 8'h30);
        cmp({5'h0, detect_trip_select, warn_trip_select, stop_depth_ctrl}, 8'h06);
        bus(4'h4, 1'h1, 8'h11);
        rd(4'h4, 8'h31);
        cmp({5'h0, detect_trip_select, warn_trip_select, stop_depth_ctrl}, 8'h07);
    endtask
    // Detect flag, acknowledge, reset and interrupt
    task automatic t_detect;
        lv_detect_cmp <= 1'h1;
        tick(6);
        rd(4'h0, 8'h9C);
        cmp({6'h0, lv_reset_req, irq}, 8'h02);
        bus(4'h0, 1'h1, 8'h64);
        rd(4'h0, 8'h24);
        lv_detect_cmp <= 1'h0;
        tick(4);
        lv_detect_cmp <= 1'h1;
        tick(6);
        cmp({6'h0, lv_reset_req, irq}, 8'h01);
        bus(4'h0, 1'h1, 8'h40);
        lv_detect_cmp <= 1'h0;
        tick(4);
        lv_detect_cmp <= 1'h1;
        tick(6);
        rd(4'h0, 8'h00);
        cmp({6'h0, lv_reset_req, irq}, 8'h00);
        lv_detect_cmp <= 1'h0;
    endtask
    // Stop gating and bandgap buffer
    task automatic t_stop;
        bus(4'h0, 1'h1, 8'h0D);
        in_stop <= 1'h1;
        tick(4);
        cmp({6'h0, lv_detect_active, bandgap_buffer_en}, 8'h03);
        bus(4'h0, 1'h1, 8'h05);
        tick(4);
        cmp({6'h0, lv_detect_active, bandgap_buffer_en}, 8'h01);
        in_stop <= 1'h0;
    endtask
    // Warning and partial power down flags with interrupt status
    task automatic t_flags;
        lv_warn_cmp <= 1'h1;
        tick(6);
        bus(4'h4, 1'h1, 8'h51);
        rd(4'h4, 8'hB1);
        lv_warn_cmp <= 1'h0;
        tick(6);
        rd(4'h4, 8'hB1);
        bus(4'h4, 1'h1, 8'h51);
        rd(4'h4, 8'h31);
        bus(4'hC, 1'h1, 8'h04);
        ppd_recovered <= 1'h1;
        tick(6);
        rd(4'h4, 8'h39);
        cmp({7'h0, irq}, 8'h01);
        bus(4'hC, 1'h1, 8'h00);
        rd(4'h8, 8'h07);
        cmp({7'h0, irq}, 8'h00);
        bus(4'h4, 1'h1, 8'h15);
        bus(4'h8, 1'h1, 8'h07);
        bus(4'hC, 1'h1, 8'h07);
        rd(4'h4, 8'h31);
        cmp({7'h0, irq}, 8'h00);
        ppd_recovered <= 1'h0;
    endtask
    // Main sequence
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata, lv_detect_cmp, lv_warn_cmp} = '0;
        {in_stop, ppd_recovered, failures, n_compared} = '0;
        por_event = 1'h1;
        rst(1'h1);
        t_once;
        t_detect;
        t_stop;
        t_flags;
        summarize;
    end
endmodule
`default_nettype wire
